// ==== rtl/iqdc_pkg.sv ====
// Shared constants for the IQ constant level and power detector block.
package iqdc_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_I_LEVEL_LOW = 8'h76;
  localparam logic [7:0] ADDR_I_LEVEL_HIGH = 8'h77;
  localparam logic [7:0] ADDR_Q_LEVEL_LOW = 8'h78;
  localparam logic [7:0] ADDR_Q_LEVEL_HIGH = 8'h79;
  localparam logic [7:0] ADDR_POWER_DETECTOR_CONTROL = 8'h7A;
  localparam logic [7:0] ADDR_POWER_THRESHOLD_LOW = 8'h7B;
  localparam logic [7:0] ADDR_POWER_THRESHOLD_HIGH = 8'h7C;
  localparam logic [7:0] ADDR_POWER_AVERAGE_LOW = 8'h7D;
  localparam logic [7:0] ADDR_POWER_AVERAGE_HIGH = 8'h7E;

  // Field layout of the detector control register.
  localparam int ENABLE_BIT = 7;
  localparam int WINDOW_CODE_MSB = 3;
  localparam int WINDOW_CODE_LSB = 0;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h8F;

  // Reset values of the writable registers.
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Averaging window: 2**(code + WINDOW_BASE_LOG2) pairs.
  localparam int WINDOW_BASE_LOG2 = 6;
  localparam int COUNT_WIDTH = 22;
  localparam int SQUARE_SUM_WIDTH = 32;
  localparam int ACC_WIDTH = 53;
  localparam int AVG_SCALE_SHIFT = 16;

  // Per-path level selection codes.
  typedef enum logic [1:0] {
    IQDC_SEL_NORMAL = 2'b00,
    IQDC_SEL_UNTIL_ILA = 2'b01,
    IQDC_SEL_CONST_A = 2'b10,
    IQDC_SEL_CONST_B = 2'b11
  } iqdc_level_select_e;
endpackage

// ==== rtl/iqdc_power_acc.sv ====
// Power accumulator that averages I squared plus Q squared over a programmable window.
`timescale 1ns/1ps
module iqdc_power_acc (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control.
  input wire logic enable_i,
  input wire logic [3:0] window_code_i,
  // Sample pairs.
  input wire logic pair_valid_i,
  input wire logic [15:0] i_sample_i,
  input wire logic [15:0] q_sample_i,
  // Result.
  output logic [15:0] average_o,
  output logic average_update_o
);
  typedef struct packed {
    logic [iqdc_pkg::ACC_WIDTH-1:0] acc;
    logic [iqdc_pkg::COUNT_WIDTH-1:0] count;
    logic [15:0] average;
    logic update;
  } iqdc_acc_s;

  iqdc_acc_s state_q;
  iqdc_acc_s state_d;

  // Last count value of a window, 2**(code + 6) - 1.
  function automatic logic [iqdc_pkg::COUNT_WIDTH-1:0] iqdc_last_count(input logic [3:0] code);
    logic [iqdc_pkg::COUNT_WIDTH-1:0] one;
    one = {{(iqdc_pkg::COUNT_WIDTH-1){1'b0}}, 1'b1};
    // Five bits for the shift: codes above 9 plus the base would wrap a four-bit sum.
    return (one << (5'(code) + 5'(iqdc_pkg::WINDOW_BASE_LOG2))) - one;
  endfunction

  logic signed [31:0] i_square;
  logic signed [31:0] q_square;
  logic [iqdc_pkg::SQUARE_SUM_WIDTH-1:0] square_sum;
  logic [iqdc_pkg::ACC_WIDTH-1:0] acc_next;
  logic [iqdc_pkg::ACC_WIDTH-1:0] acc_shifted;

  // Instantaneous power of the current pair; both squares are non-negative so the sum fits 32 bits.
  assign i_square = $signed(i_sample_i) * $signed(i_sample_i);
  assign q_square = $signed(q_sample_i) * $signed(q_sample_i);
  assign square_sum = 32'(unsigned'(i_square)) + 32'(unsigned'(q_square));
  assign acc_next = state_q.acc + {{(iqdc_pkg::ACC_WIDTH-iqdc_pkg::SQUARE_SUM_WIDTH){1'b0}}, square_sum};
  // Mean over the window, then the top 16 of the 32 power bits.
  assign acc_shifted = acc_next >> (6'(window_code_i) + 6'(iqdc_pkg::WINDOW_BASE_LOG2) +
                                    6'(iqdc_pkg::AVG_SCALE_SHIFT));

  // Accumulate pairs while enabled and publish the mean when a window completes.
  always_comb begin
    state_d = state_q;
    state_d.update = 1'b0;
    if (!enable_i) begin
      state_d.acc = '0;
      state_d.count = '0;
    end else if (pair_valid_i) begin
      if (state_q.count >= iqdc_last_count(window_code_i)) begin
        state_d.average = acc_shifted[15:0];
        state_d.update = 1'b1;
        state_d.acc = '0;
        state_d.count = '0;
      end else begin
        state_d.acc = acc_next;
        state_d.count = state_q.count + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign average_o = state_q.average;
  assign average_update_o = state_q.update;
endmodule

// ==== rtl/iqdc_level_power.sv ====
// IQ constant level substitution and signal power detector with its byte register file.
// Function
// - Hold 16-bit I constant level in byte registers 0x76 low and 0x77 high.
// - Hold 16-bit Q constant level in byte registers 0x78 low and 0x79 high.
// - Selection 10 or 11 feeds that path's constant level instead of interface data.
// - Power detector runs only while bit 7 of register 0x7A is set.
// - Code 0000 averages 64 pairs; each step doubles, up to 2097152 pairs.
// - Read/write 16-bit threshold in byte registers 0x7B low and 0x7C high.
// - Read-only 16-bit average in 0x7D low and 0x7E high; zero after reset.
`timescale 1ns/1ps
module iqdc_level_power (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control register port, byte wide.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Level selection and link status.
  input wire logic [1:0] i_level_select_i,
  input wire logic [1:0] q_level_select_i,
  input wire logic end_of_ila_i,
  // Interface data output from the link.
  input wire logic interface_data_valid_i,
  input wire logic [15:0] interface_data_i_i,
  input wire logic [15:0] interface_data_q_i,
  // Processing input.
  output logic dsp_valid_o,
  output logic [15:0] dsp_i_o,
  output logic [15:0] dsp_q_o,
  // Detector status.
  output logic power_above_threshold_o,
  output logic power_average_update_o
);
  typedef struct packed {
    logic [15:0] i_constant_level;
    logic [15:0] q_constant_level;
    logic [7:0] detector_control;
    logic [15:0] power_threshold;
    logic [7:0] rdata;
    logic rvalid;
    logic dsp_valid;
    logic [15:0] dsp_i;
    logic [15:0] dsp_q;
    logic above;
  } iqdc_top_s;

  iqdc_top_s state_q;
  iqdc_top_s state_d;

  logic [15:0] power_average;
  logic average_update;
  logic power_detector_enable;
  logic [3:0] averaging_window_code;

  // True when the selection replaces interface data with the constant level.
  function automatic logic iqdc_use_constant(input logic [1:0] sel, input logic ila_done);
    logic result;
    result = 1'b0;
    case (sel)
      iqdc_pkg::IQDC_SEL_NORMAL: result = 1'b0;
      iqdc_pkg::IQDC_SEL_UNTIL_ILA: result = !ila_done;
      iqdc_pkg::IQDC_SEL_CONST_A: result = 1'b1;
      iqdc_pkg::IQDC_SEL_CONST_B: result = 1'b1;
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // Detector control fields.
  assign power_detector_enable = state_q.detector_control[iqdc_pkg::ENABLE_BIT];
  assign averaging_window_code = state_q.detector_control[iqdc_pkg::WINDOW_CODE_MSB:iqdc_pkg::WINDOW_CODE_LSB];

  // Averaging engine.
  iqdc_power_acc u_power_acc (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(power_detector_enable),
    .window_code_i(averaging_window_code),
    .pair_valid_i(interface_data_valid_i),
    .i_sample_i(interface_data_i_i),
    .q_sample_i(interface_data_q_i),
    .average_o(power_average),
    .average_update_o(average_update)
  );

  // Register writes, register reads and the data path to the processing input.
  always_comb begin
    state_d = state_q;
    state_d.rvalid = reg_read_i;
    if (reg_write_i) begin
      case (reg_addr_i)
        iqdc_pkg::ADDR_I_LEVEL_LOW: state_d.i_constant_level[7:0] = reg_wdata_i;
        iqdc_pkg::ADDR_I_LEVEL_HIGH: state_d.i_constant_level[15:8] = reg_wdata_i;
        iqdc_pkg::ADDR_Q_LEVEL_LOW: state_d.q_constant_level[7:0] = reg_wdata_i;
        iqdc_pkg::ADDR_Q_LEVEL_HIGH: state_d.q_constant_level[15:8] = reg_wdata_i;
        iqdc_pkg::ADDR_POWER_DETECTOR_CONTROL: state_d.detector_control = reg_wdata_i & iqdc_pkg::CONTROL_WRITE_MASK;
        iqdc_pkg::ADDR_POWER_THRESHOLD_LOW: state_d.power_threshold[7:0] = reg_wdata_i;
        iqdc_pkg::ADDR_POWER_THRESHOLD_HIGH: state_d.power_threshold[15:8] = reg_wdata_i;
        default: state_d.rvalid = reg_read_i; // Read-only and unmapped writes are ignored.
      endcase
    end
    if (reg_read_i) begin
      case (reg_addr_i)
        iqdc_pkg::ADDR_I_LEVEL_LOW: state_d.rdata = state_q.i_constant_level[7:0];
        iqdc_pkg::ADDR_I_LEVEL_HIGH: state_d.rdata = state_q.i_constant_level[15:8];
        iqdc_pkg::ADDR_Q_LEVEL_LOW: state_d.rdata = state_q.q_constant_level[7:0];
        iqdc_pkg::ADDR_Q_LEVEL_HIGH: state_d.rdata = state_q.q_constant_level[15:8];
        iqdc_pkg::ADDR_POWER_DETECTOR_CONTROL: state_d.rdata = state_q.detector_control;
        iqdc_pkg::ADDR_POWER_THRESHOLD_LOW: state_d.rdata = state_q.power_threshold[7:0];
        iqdc_pkg::ADDR_POWER_THRESHOLD_HIGH: state_d.rdata = state_q.power_threshold[15:8];
        iqdc_pkg::ADDR_POWER_AVERAGE_LOW: state_d.rdata = power_average[7:0];
        iqdc_pkg::ADDR_POWER_AVERAGE_HIGH: state_d.rdata = power_average[15:8];
        default: state_d.rdata = iqdc_pkg::BYTE_RESET;
      endcase
    end
    // Each path picks interface data or its constant level independently.
    state_d.dsp_valid = interface_data_valid_i;
    if (interface_data_valid_i) begin
      state_d.dsp_i = iqdc_use_constant(i_level_select_i, end_of_ila_i) ?
                      state_q.i_constant_level : interface_data_i_i;
      state_d.dsp_q = iqdc_use_constant(q_level_select_i, end_of_ila_i) ?
                      state_q.q_constant_level : interface_data_q_i;
    end
    // Threshold comparison follows each published average.
    if (average_update) begin
      state_d.above = power_average > state_q.power_threshold;
    end
  end

  // State register; all fields clear on reset.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o = state_q.rdata;
  assign reg_rvalid_o = state_q.rvalid;
  assign dsp_valid_o = state_q.dsp_valid;
  assign dsp_i_o = state_q.dsp_i;
  assign dsp_q_o = state_q.dsp_q;
  assign power_above_threshold_o = state_q.above;
  assign power_average_update_o = average_update;
endmodule

// ==== testbench/iqdc_level_power_checker.sv ====
// Port checks for the level substitution and power detector block.
`timescale 1ns/1ps
module iqdc_level_power_checker (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port.
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Data path.
  input wire logic [1:0] i_level_select_i,
  input wire logic [1:0] q_level_select_i,
  input wire logic interface_data_valid_i,
  input wire logic [15:0] interface_data_i_i,
  input wire logic [15:0] interface_data_q_i,
  input wire logic dsp_valid_o,
  input wire logic [15:0] dsp_i_o,
  input wire logic [15:0] dsp_q_o,
  input wire logic power_average_update_o
);
  // Every check uses the one clock and rests during reset.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Read answers come exactly one cycle after the strobe, never otherwise.
  read_answer_a: assert property (reg_read_i |=> reg_rvalid_o) else $error("read not answered");
  no_stray_a: assert property (!reg_read_i |=> !reg_rvalid_o) else $error("stray read answer");
  rdata_hold_a: assert property (!reg_read_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  // The processing input follows the interface one cycle later.
  dsp_valid_a: assert property (dsp_valid_o == $past(interface_data_valid_i)) else $error("valid lag");
  pass_i_a: assert property (interface_data_valid_i && i_level_select_i == 2'h0
    |=> dsp_i_o == $past(interface_data_i_i)) else $error("I not passed");
  pass_q_a: assert property (interface_data_valid_i && q_level_select_i == 2'h0
    |=> dsp_q_o == $past(interface_data_q_i)) else $error("Q not passed");
  dsp_hold_a: assert property (!interface_data_valid_i |=> $stable(dsp_i_o) && $stable(dsp_q_o))
    else $error("data moved without pair");
  // Published averages are at least 9 cycles apart and each ends on a taken pair.
  window_gap_a: assert property (power_average_update_o |=> !power_average_update_o [*8])
    else $error("windows too close");
  window_cause_a: assert property (power_average_update_o |-> $past(interface_data_valid_i))
    else $error("window ended without pair");
  // Main scenarios.
  cover property (power_average_update_o);
  cover property (reg_read_i ##1 reg_rvalid_o);
  cover property (interface_data_valid_i && i_level_select_i[1]);
endmodule

// ==== testbench/iqdc_level_power_tb.sv ====
// Self-checking bench for the level substitution and power detector block.
`timescale 1ns/1ps
module iqdc_level_power_tb;
  logic clock_i, sys_rst_i, reg_write_i, reg_read_i, end_of_ila_i, interface_data_valid_i;
  logic reg_rvalid_o, dsp_valid_o, power_above_threshold_o, power_average_update_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] i_level_select_i, q_level_select_i;
  logic [15:0] interface_data_i_i, interface_data_q_i, dsp_i_o, dsp_q_o, e;
  int miscompares = 0, total_checks = 0, pulses = 0;
  // Device under test.
  iqdc_level_power i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .i_level_select_i(i_level_select_i),
    .q_level_select_i(q_level_select_i), .end_of_ila_i(end_of_ila_i),
    .interface_data_valid_i(interface_data_valid_i), .interface_data_i_i(interface_data_i_i),
    .interface_data_q_i(interface_data_q_i), .dsp_valid_o(dsp_valid_o), .dsp_i_o(dsp_i_o),
    .dsp_q_o(dsp_q_o), .power_above_threshold_o(power_above_threshold_o),
    .power_average_update_o(power_average_update_o));
  // Clock of 4 ns and a count of published averages.
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (power_average_update_o === 1'b1) pulses++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1;
    check({15'h0000, reg_rvalid_o}, 16'h0001);
    check({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask
  // Holds valid for n edges with one constant pair.
  task automatic pairs(input int n, input logic [15:0] i, input logic [15:0] q);
    @(posedge clock_i);
    interface_data_valid_i <= 1'b1;
    interface_data_i_i <= i;
    interface_data_q_i <= q;
    repeat (n) @(posedge clock_i);
    interface_data_valid_i <= 1'b0;
    #1;
  endtask
  task automatic wins(input int n);
    repeat (3) @(posedge clock_i);
    #1;
    check(16'(pulses), 16'(n));
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A run needs about 350 cycles.
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {sys_rst_i, reg_write_i, reg_read_i, end_of_ila_i, interface_data_valid_i} = 5'h10;
    {reg_addr_i, reg_wdata_i, i_level_select_i, q_level_select_i} = 20'h00000;
    {interface_data_i_i, interface_data_q_i} = 32'h00000000;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // Writable bytes read back; control keeps only bits 7 and 3..0.
    for (int k = 0; k < 7; k++) wr(8'h76 + 8'(k), 8'hF0 + 8'(k));
    for (int k = 0; k < 7; k++) rd(8'h76 + 8'(k), (k == 4) ? 8'h84 : 8'hF0 + 8'(k));
    wr(8'h7D, 8'hFF);
    rd(8'h7D, 8'h00);
    rd(8'h75, 8'h00);
    wr(8'h7A, 8'h00);
    $display("Register test done");
    // Every selection code, then code 01 after the link is up.
    for (int s = 0; s < 5; s++) begin
      // Selection inputs change on a rising edge, like every other stimulus.
      @(posedge clock_i);
      i_level_select_i <= (s == 4) ? 2'b01 : 2'(s);
      q_level_select_i <= (s == 4) ? 2'b01 : 2'(s);
      end_of_ila_i <= (s == 4);
      pairs(1, 16'h5A5A, 16'hA5A5);
      e = (s == 0 || s == 4) ? 16'h5A5A : 16'hF1F0;
      check(dsp_i_o, e);
      check(dsp_q_o, (s == 0 || s == 4) ? 16'hA5A5 : 16'hF3F2);
    end
    $display("Level test done");
    // Windows of 64 and 128 pairs; each pair has power 2 to the 29.
    wr(8'h7C, 8'h1F);
    wr(8'h7A, 8'h80);
    pairs(63, 16'h4000, 16'h4000);
    wins(0);
    pairs(1, 16'h4000, 16'h4000);
    wins(1);
    check({15'h0000, power_above_threshold_o}, 16'h0001);
    rd(8'h7D, 8'h00);
    rd(8'h7E, 8'h20);
    // A threshold equal to the next average must leave the status low, as the test is strict.
    wr(8'h7B, 8'h00);
    wr(8'h7C, 8'h20);
    wr(8'h7A, 8'h81);
    pairs(127, 16'h4000, 16'h4000);
    wins(1);
    pairs(1, 16'h4000, 16'h4000);
    wins(2);
    check({15'h0000, power_above_threshold_o}, 16'h0000);
    rd(8'h7E, 8'h20);
    wr(8'h7A, 8'h01);
    pairs(64, 16'h4000, 16'h4000);
    wins(2);
    $display("Detector test done");
    tally_and_finish();
  end
endmodule
// Port checks ride along with every instance of the block.
bind iqdc_level_power iqdc_level_power_checker i_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .i_level_select_i(i_level_select_i), .q_level_select_i(q_level_select_i),
  .interface_data_valid_i(interface_data_valid_i), .interface_data_i_i(interface_data_i_i),
  .interface_data_q_i(interface_data_q_i), .dsp_valid_o(dsp_valid_o), .dsp_i_o(dsp_i_o),
  .dsp_q_o(dsp_q_o), .power_average_update_o(power_average_update_o));
